//--- shared/dduc_pkg.sv
/*
  constants, control word layout and mode codes for the update and
  control word block of the synthesizer.
  assumes nothing; every design file refers to it by package::name.
*/
package dduc_pkg;

  // byte addresses of the first byte of each register on the write port
  localparam logic [7:0] ADDR_CTRL = 8'h1d;
  localparam logic [7:0] ADDR_IVL = 8'h16;

  // pll range and pll bypass power up set, everything else clear
  localparam logic [31:0] CTRL_RESET = 32'h0060_0000;
  // reserved bits 31:29, 23, 7 and 3:2 never reach the buffer
  localparam logic [31:0] CTRL_WMASK = 32'h1f7f_ff73;
  localparam logic [31:0] IVL_RESET = 32'h0000_0040;
  localparam logic [31:0] IVL_SHORT = 32'h0000_0005;

  // internal strobe is held high this many cycles after a transfer
  localparam int unsigned PULSE_CYCLES = 8;
  localparam logic [3:0] PULSE_LOAD = 4'(PULSE_CYCLES - 1);
  localparam logic [3:0] PULSE_ZERO = 4'h0;
  localparam logic [3:0] PULSE_STEP = 4'h1;

  typedef logic [32:0] dduc_count_t;
  localparam dduc_count_t PERIOD_MIN = 33'h0_0000_0001;
  localparam dduc_count_t COUNT_ZERO = 33'h0_0000_0000;

  typedef enum logic [2:0] {
    MODE_SINGLE_TONE = 3'h0,
    MODE_FREQ_SHIFT_KEYING = 3'h1,
    MODE_RAMPED_SHIFT = 3'h2,
    MODE_CHIRP = 3'h3,
    MODE_PHASE_SHIFT_KEYING = 3'h4
  } dduc_mode_e;

  typedef struct packed {
    logic [2:0] open_hi;      // 31:29
    logic cmp_pd;             // 28
    logic halt_bit;           // 27
    logic aux_dac_pd;         // 26
    logic dac_pd;             // 25
    logic dig_pd;             // 24
    logic rsv23;              // 23
    logic pll_hi_range;       // 22
    logic pll_bypass;         // 21
    logic [4:0] ref_mult;     // 20:16
    logic clr_acc1;           // 15
    logic clr_acc_all;        // 14
    logic triangle;           // 13
    logic spare12;            // 12
    dduc_mode_e mode;         // 11:9
    logic int_update;         // 8
    logic rsv7;               // 7
    logic sinc_bypass;        // 6
    logic keying_en;          // 5
    logic keying_int;         // 4
    logic [1:0] rsv3_2;       // 3:2
    logic lsb_first;          // 1
    logic sdo_active;         // 0
  } dduc_ctrl_s;

  localparam dduc_ctrl_s CTRL_RESET_S = dduc_ctrl_s'(CTRL_RESET);
  localparam logic [4:0] MULT_OFF = 5'h00;

  // edges fall twice the programmed value apart; zero still counts one
  function automatic dduc_count_t period_of(input logic [31:0] ivl);
    dduc_count_t p;
    p = {ivl, 1'b0};
    if (p == COUNT_ZERO) begin
      p = PERIOD_MIN;
    end
    return p;
  endfunction : period_of

endpackage : dduc_pkg

//--- hw/dduc_update_gen.sv
/*
  internal update generator: fires a one-cycle transfer request every
  period_of(interval) system clock cycles.
  assumes interval comes from the active bank and enable is the
  internal update mode bit.
*/
`timescale 1ns/100ps
`default_nettype none

module dduc_update_gen (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic [31:0] interval,
  output logic fire
);

  dduc_pkg::dduc_count_t cnt_q;
  dduc_pkg::dduc_count_t period;

  assign period = dduc_pkg::period_of(interval);
  assign fire = enable && (cnt_q >= (period - dduc_pkg::PERIOD_MIN));

  // count up from zero, so an interval loaded by a fire, or by the
  // transfer that enables the mode, sets the very next spacing
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= dduc_pkg::COUNT_ZERO;
    end else if (!enable || fire) begin
      cnt_q <= dduc_pkg::COUNT_ZERO;
    end else begin
      cnt_q <= cnt_q + dduc_pkg::PERIOD_MIN;
    end
  end

  chk_gen_idle:
    assert property (@(posedge clk_sys) disable iff (sys_rst)
      $rose(enable) && (period != dduc_pkg::PERIOD_MIN) |-> !fire)
    else $error("update generator fired at once after enable");

endmodule : dduc_update_gen

`default_nettype wire

//--- hw/dduc_bank.sv
/*
  staging buffer, active register bank, update strobe pin handling and
  control word decode of the synthesizer.
  assumes the write and read ports and the strobe pin input are
  synchronous to clk_sys; the pin's wire level is resolved outside.
*/
`timescale 1ns/100ps
`default_nettype none

module dduc_bank (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [31:0] wr_data,
  input wire logic rd_en,
  input wire logic [7:0] rd_addr,
  output logic [31:0] rd_data,
  input wire logic update_strobe_pin_i,
  output logic update_strobe_pin_o,
  output logic update_strobe_pin_oe,
  output logic xfer_done,
  output logic acc1_clear,
  output dduc_pkg::dduc_ctrl_s active_ctrl,
  output logic [31:0] active_interval,
  output logic [4:0] pll_mult_eff,
  output logic pll_power_down,
  output logic digital_clk_stop,
  output logic op_stopped
);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  logic [31:0] buf_ctrl_q;
  logic [31:0] buf_ivl_q;
  dduc_pkg::dduc_ctrl_s buf_view;
  dduc_pkg::dduc_ctrl_s bank_next;
  dduc_pkg::dduc_ctrl_s ctrl_q;
  logic [31:0] ivl_q;
  logic pin_prev_q;
  logic ext_rise;
  logic gen_fire;
  logic gen_q;
  logic xfer;
  logic xfer_q;
  logic halted_q;
  logic acc1_q;
  logic [3:0] hi_cnt_q;
  logic pin_q;
  logic oe_q;
  logic [4:0] mult_q;
  logic pll_pd_q;
  logic dig_stop_q;
  logic [31:0] rd_q;

  assign buf_view = dduc_pkg::dduc_ctrl_s'(buf_ctrl_q);

  // host writes only touch the buffer, never the bank
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      buf_ctrl_q <= dduc_pkg::CTRL_RESET;
      buf_ivl_q <= dduc_pkg::IVL_RESET;
    end else if (wr_en) begin
      if (wr_addr == dduc_pkg::ADDR_CTRL) begin
        buf_ctrl_q <= wr_data & dduc_pkg::CTRL_WMASK;
      end
      if (wr_addr == dduc_pkg::ADDR_IVL) begin
        buf_ivl_q <= wr_data;
      end
    end
  end

  // pin is only looked at while it is an input
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= update_strobe_pin_i;
    end
  end

  assign ext_rise = !ctrl_q.int_update && update_strobe_pin_i &&
                    !pin_prev_q;

  dduc_update_gen u_gen (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .enable(ctrl_q.int_update && !halted_q),
    .interval(ivl_q),
    .fire(gen_fire)
  );

  // a stopped device ignores every further transfer
  assign xfer = (ext_rise || gen_fire) && !halted_q;

  // the one-shot bit never lands in the bank, so it clears itself
  always_comb begin
    bank_next = buf_view;
    bank_next.clr_acc1 = 1'b0;
  end

  // bank copy; serial format bits change here too, mid-access or not
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q <= dduc_pkg::CTRL_RESET_S;
      ivl_q <= dduc_pkg::IVL_RESET;
    end else if (xfer) begin
      ctrl_q <= bank_next;
      ivl_q <= buf_ivl_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      xfer_q <= 1'b0;
      gen_q <= 1'b0;
      acc1_q <= 1'b0;
    end else begin
      xfer_q <= xfer;
      gen_q <= gen_fire && !halted_q;
      acc1_q <= xfer && buf_view.clr_acc1;
    end
  end

  // sticky until reset: nothing but sys_rst clears it
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      halted_q <= 1'b0;
    end else if (xfer && buf_view.halt_bit) begin
      halted_q <= 1'b1;
    end
  end

  // pulse stretcher; reloading on each fire merges short periods into a
  // steady high, so the pin stops marking single transfers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hi_cnt_q <= dduc_pkg::PULSE_ZERO;
      pin_q <= 1'b0;
    end else if (gen_fire && !halted_q) begin
      hi_cnt_q <= dduc_pkg::PULSE_LOAD;
      pin_q <= 1'b1;
    end else if (hi_cnt_q != dduc_pkg::PULSE_ZERO) begin
      hi_cnt_q <= hi_cnt_q - dduc_pkg::PULSE_STEP;
      pin_q <= 1'b1;
    end else begin
      pin_q <= 1'b0;
    end
  end

  // decoded outputs follow the bank, loaded on the same edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      oe_q <= dduc_pkg::CTRL_RESET_S.int_update;
      pll_pd_q <= dduc_pkg::CTRL_RESET_S.pll_bypass;
      mult_q <= dduc_pkg::MULT_OFF;
      dig_stop_q <= dduc_pkg::CTRL_RESET_S.dig_pd;
    end else if (xfer) begin
      oe_q <= bank_next.int_update;
      pll_pd_q <= bank_next.pll_bypass;
      mult_q <= bank_next.pll_bypass ? dduc_pkg::MULT_OFF :
                bank_next.ref_mult;
      dig_stop_q <= bank_next.dig_pd || bank_next.halt_bit;
    end
  end

  // reads show the active bank, not the buffer; others read zero
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_q <= 32'h0000_0000;
    end else if (rd_en) begin
      if (rd_addr == dduc_pkg::ADDR_CTRL) begin
        rd_q <= ctrl_q;
      end else if (rd_addr == dduc_pkg::ADDR_IVL) begin
        rd_q <= ivl_q;
      end else begin
        rd_q <= 32'h0000_0000;
      end
    end
  end

  // field outputs ride in active_ctrl: power-downs, pll range, all-accumulator clear,
  // sweep, mode, sinc bypass, keying and serial format
  assign active_ctrl = ctrl_q;
  assign active_interval = ivl_q;
  assign update_strobe_pin_o = pin_q;
  assign update_strobe_pin_oe = oe_q;
  assign xfer_done = xfer_q;
  assign acc1_clear = acc1_q;
  assign pll_mult_eff = mult_q;
  assign pll_power_down = pll_pd_q;
  assign digital_clk_stop = dig_stop_q;
  assign op_stopped = halted_q;
  assign rd_data = rd_q;

  // helper: cycles between generator fires, armed from the first fire while it runs
  dduc_pkg::dduc_count_t since_q;
  dduc_pkg::dduc_count_t exp_q;
  logic armed_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || !ctrl_q.int_update || halted_q) begin
      since_q <= dduc_pkg::COUNT_ZERO;
      exp_q <= dduc_pkg::COUNT_ZERO;
      armed_q <= 1'b0;
    end else if (gen_fire) begin
      since_q <= dduc_pkg::PERIOD_MIN;
      // the fire edge also loads the buffered interval into the bank
      exp_q <= dduc_pkg::period_of(buf_ivl_q);
      armed_q <= 1'b1;
    end else begin
      since_q <= since_q + dduc_pkg::PERIOD_MIN;
    end
  end

  sequence seq_gen_pulse;
    gen_q ##0 update_strobe_pin_o [*8];
  endsequence

  sequence seq_short_run;
    gen_q ##1 (armed_q && ctrl_q.int_update &&
               (ivl_q < dduc_pkg::IVL_SHORT)) [*8];
  endsequence

  chk_bank_load:
    assert property (xfer_q |-> ivl_q == $past(buf_ivl_q) &&
                     ctrl_q.int_update == $past(buf_view.int_update))
    else $error("bank did not take the buffer on transfer");

  chk_bank_hold:
    assert property (!xfer_q |-> $stable(ivl_q) && $stable(ctrl_q))
    else $error("bank changed without a transfer");

  chk_ext_edge:
    assert property (!ctrl_q.int_update && !halted_q &&
                     $rose(update_strobe_pin_i) |=> xfer_q)
    else $error("external rising edge gave no transfer");

  chk_held_once:
    assert property (!ctrl_q.int_update && update_strobe_pin_i &&
                     $past(update_strobe_pin_i) |=> !xfer_q)
    else $error("held strobe caused another transfer");

  chk_pulse_width:
    assert property (gen_q |-> seq_gen_pulse)
    else $error("internal strobe shorter than eight cycles");

  chk_short_high:
    assert property (seq_short_run |-> update_strobe_pin_o)
    else $error("strobe dropped with a short interval");

  chk_fire_spacing:
    assert property (gen_fire && armed_q |-> since_q == exp_q)
    else $error("internal update spacing is not twice the interval");

  chk_halt_sticky:
    assert property (halted_q |=> halted_q && !xfer_q && digital_clk_stop)
    else $error("stopped device resumed or transferred");

  chk_rsv_zero:
    assert property ((ctrl_q & ~dduc_pkg::CTRL_WMASK) == 32'h0000_0000)
    else $error("reserved control bit set in the bank");

  chk_pll_mult:
    assert property (pll_mult_eff == (ctrl_q.pll_bypass ?
                     dduc_pkg::MULT_OFF : ctrl_q.ref_mult))
    else $error("multiplier not ignored under bypass");

  chk_acc1_shot:
    assert property (acc1_clear |-> xfer_q && !ctrl_q.clr_acc1 &&
                     $past(buf_view.clr_acc1))
    else $error("accumulator clear pulse without its cause");

  chk_pin_dir:
    assert property (update_strobe_pin_oe == ctrl_q.int_update)
    else $error("strobe pin direction does not follow the mode");

  // decoded outputs, the stop flag, the ignored pin and the buffer mask against the bank or buffer bits they come from

  chk_acc1_pulse:
    assert property (xfer && buf_view.clr_acc1 |=> acc1_clear)
    else $error("set clear bit gave no accumulator clear pulse");

  chk_halt_entry:
    assert property (xfer && buf_view.halt_bit |=> op_stopped)
    else $error("copied stop bit did not stop the device");

  chk_dig_stop:
    assert property (digital_clk_stop ==
                     (ctrl_q.dig_pd || ctrl_q.halt_bit))
    else $error("digital clock stop does not follow the bank");

  chk_pll_down:
    assert property (pll_power_down == ctrl_q.pll_bypass)
    else $error("pll power-down does not follow the bypass bit");

  chk_pin_ignored:
    assert property (ctrl_q.int_update && !gen_fire |=> !xfer_q)
    else $error("strobe pin caused a transfer in internal mode");

  chk_buf_masked:
    assert property ((buf_ctrl_q & ~dduc_pkg::CTRL_WMASK) == 32'h0000_0000)
    else $error("reserved control bit reached the buffer");

  // reads must show the bank, never the buffer
  chk_rd_ctrl:
    assert property (rd_en && rd_addr == dduc_pkg::ADDR_CTRL |=>
                     rd_data == $past(ctrl_q))
    else $error("control read did not return the bank");

  chk_rd_ivl:
    assert property (rd_en && rd_addr == dduc_pkg::ADDR_IVL |=>
                     rd_data == $past(ivl_q))
    else $error("interval read did not return the bank");

endmodule : dduc_bank

`default_nettype wire

//--- verif/dduc_host.sv
/*
  host model: strobes the update pin while the device listens to it.
  assumes fire is a one-cycle request synchronous to clk_sys.
*/
`timescale 1ns/100ps
`default_nettype none

module dduc_host (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic fire,
  input wire logic [3:0] hold,
  input wire logic dev_o,
  input wire logic dev_oe,
  output logic pin
);
  logic [3:0] cnt_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
    end else if (fire) begin
      cnt_q <= (hold < 4'h2) ? 4'h2 : hold;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  // host lets go of the wire while the device drives it
  assign pin = dev_oe ? dev_o : (cnt_q != 4'h0);
endmodule : dduc_host

`default_nettype wire

//--- verif/dds_update_and_control_word_tb.sv
/*
  self-checking bench for the update and control word bank.
  assumes dduc_pkg and the host model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module dds_update_and_control_word_tb;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] ivl;
    logic acc;
  } dduc_note_s;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic fire = 1'b0;
  logic [7:0] wr_addr = 8'h00;
  logic [7:0] rd_addr = 8'h00;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] rd_data, ivl_o, bctrl, bivl, bank, w;
  logic [3:0] hold = 4'h2;
  logic pin, pin_o, pin_oe, xfer_done, acc1_clear, pll_pd, dcs, stopped;
  logic [4:0] mult;
  dduc_pkg::dduc_ctrl_s act;
  dduc_note_s q[$];
  dduc_note_s last;
  logic repeat_ok = 1'b0;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 58051;
  int n, h;

  always #12.5 clk_sys = ~clk_sys;

  dduc_bank dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .update_strobe_pin_i(pin),
    .update_strobe_pin_o(pin_o), .update_strobe_pin_oe(pin_oe),
    .xfer_done(xfer_done), .acc1_clear(acc1_clear), .active_ctrl(act),
    .active_interval(ivl_o), .pll_mult_eff(mult),
    .pll_power_down(pll_pd), .digital_clk_stop(dcs),
    .op_stopped(stopped));

  dduc_host host_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .fire(fire),
    .hold(hold), .dev_o(pin_o), .dev_oe(pin_oe), .pin(pin));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic results;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("Error at %0t: timeout", $time);
      results();
    end
  end

  // watcher: each transfer must match the oldest note, or the last one popped while repeat_ok is set
  always @(posedge clk_sys) begin
    if (!sys_rst && xfer_done === 1'b1) begin
      if (q.size() > 0) begin
        last = q.pop_front();
      end else if (!repeat_ok) begin
        cmp(32'h1, 32'h0);
      end
      cmp(32'(act), last.ctrl);
      cmp(ivl_o, last.ivl);
      cmp(32'(acc1_clear), 32'(last.acc));
      cmp(32'(pin_oe), 32'(last.ctrl[8]));
      cmp(32'(mult), last.ctrl[21] ? 32'h0 : 32'(last.ctrl[20:16]));
      cmp(32'(pll_pd), 32'(last.ctrl[21]));
      cmp(32'(dcs), 32'(last.ctrl[24] | last.ctrl[27]));
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    if (a == dduc_pkg::ADDR_CTRL) bctrl = d & dduc_pkg::CTRL_WMASK;
    if (a == dduc_pkg::ADDR_IVL) bivl = d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    cmp(rd_data, e);
  endtask : rd

  task automatic note;
    bank = bctrl & 32'hffff_7fff;
    q.push_back({bank, bivl, bctrl[15]});
  endtask : note

  task automatic wait_empty;
    for (int i = 0; i < 60 && q.size() > 0; i++) @(posedge clk_sys);
    repeat (6) @(posedge clk_sys);
    cmp(32'(q.size()), 32'h0);
  endtask : wait_empty

  task automatic xfer(input logic [3:0] hd);
    note();
    hold <= hd;
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    wait_empty();
  endtask : xfer

  task automatic sync_x;
    for (int i = 0; i < 100 && xfer_done !== 1'b1; i++) @(posedge clk_sys);
  endtask : sync_x

  initial begin
    bctrl = dduc_pkg::CTRL_RESET;
    bivl = dduc_pkg::IVL_RESET;
    bank = bctrl;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(dduc_pkg::ADDR_CTRL, 32'h0060_0000);
    rd(dduc_pkg::ADDR_IVL, dduc_pkg::IVL_RESET);
    cmp(32'(pin_oe), 32'h0);
    for (int m = 0; m < 5; m++) begin
      w = $random(seed);
      w[11:9] = 3'(m);
      w[8] = 1'b0;
      w[15] = w[15] | (m == 1);
      w[21] = m[0];
      w[13] = w[13] & (m == 2);
      w[20:16] = 5'(w[31:24] % 8'h11) + 5'h04;
      w[27] = 1'b0;
      wr(dduc_pkg::ADDR_CTRL, w);
      wr(dduc_pkg::ADDR_IVL, $random(seed));
      wr(8'h20, $random(seed));
      rd(dduc_pkg::ADDR_CTRL, bank);
      xfer(4'(2 + m));
      rd(dduc_pkg::ADDR_CTRL, bank);
    end
    rd(8'h20, 32'h0);
    // internal updates every 20 cycles
    wr(dduc_pkg::ADDR_IVL, 32'h0000_000a);
    w[8] = 1'b1;
    w[15] = 1'b0;
    w[24] = 1'b0;
    wr(dduc_pkg::ADDR_CTRL, w);
    xfer(4'h2);
    repeat_ok = 1'b1;
    sync_x();
    n = 0;
    h = 0;
    do begin
      @(posedge clk_sys);
      n++;
      h += int'(pin_o);
    end while (xfer_done !== 1'b1 && n < 100);
    cmp(32'(n), 32'h14);
    cmp(32'(h), 32'h8);
    wr(dduc_pkg::ADDR_IVL, 32'h0000_0003);
    note();
    wait_empty();
    n = 0;
    h = 0;
    repeat (40) begin
      @(posedge clk_sys);
      h += int'(pin_o);
      n += int'(xfer_done);
    end
    cmp(32'(h), 32'h28);
    cmp(32'(n >= 6), 32'h1);
    sync_x();
    w[8] = 1'b0;
    wr(dduc_pkg::ADDR_CTRL, w);
    note();
    wait_empty();
    repeat_ok = 1'b0;
    repeat (30) @(posedge clk_sys);
    // bit 27 halts all further transfers until reset
    w[27] = 1'b1;
    wr(dduc_pkg::ADDR_CTRL, w);
    xfer(4'h2);
    cmp(32'(stopped), 32'h1);
    fire <= 1'b1;
    @(posedge clk_sys);
    fire <= 1'b0;
    repeat (8) @(posedge clk_sys);
    rd(dduc_pkg::ADDR_CTRL, bank);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    cmp(32'(stopped), 32'h0);
    rd(dduc_pkg::ADDR_CTRL, dduc_pkg::CTRL_RESET);
    results();
  end
endmodule : dds_update_and_control_word_tb

`default_nettype wire
